//--- hdl/scm_clock_control.sv
// System clock source selection and operating mode clock gating.
//
// Behaviour
// - System clock from fast or slow source.
// - Fast clock divided by two to sixty-four.
// - Slow source is RC or crystal strap.
// - Fast oscillator stops when running slow.
// - Slow clock may bridge wake-up.
// - Time base clock: slow or system/4.
// - Slow clock routed to peripheral timers.
// - Crystal pins are oscillator or general I/O.
// - Power bit: 0 quick start, 1 low power.
// - Power bit clears to zero at reset.
// - Crystal runs in both power settings.
// - Running modes clock CPU, slow on.
// - Sleep modes stop CPU, gate clocks.
// - Divider field encodes slow and ratios.
// - Select bit one picks undivided fast.
// - Halt with idle picks idle flavour.
// - Ready flag after 1024 oscillator cycles.
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module scm_clock_control
   import scm_pkg::*;
#(
   parameter int HRDY_CYCLES = SCM_HRDY_CYCLES
)
(
   // APB slave.
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Configuration straps.
   input  wire logic        cfg_slow_from_xtal,
   input  wire logic        cfg_xtal_pins_osc,
   // Oscillator ticks, one pin each, from outside the clock domain.
   input  wire logic        fast_osc_tick,
   input  wire logic        slow_osc_tick,
   // CPU halt and wake events from the core, same domain.
   input  wire logic        halt_req,
   input  wire logic        wake_req,
   // Oscillator controls.
   output logic             fast_osc_enable,
   output logic             slow_rc_enable,
   output logic             slow_xtal_enable,
   output logic             slow_xtal_power_setting,
   output logic             slow_xtal_pins_gpio,
   // Clock enables.
   output logic             cpu_clk_en,
   output logic             sys_clk_en,
   output logic             sub_clk_en,
   output logic             tbase_clk_en,
   output logic             periph_sub_clk_en,
   output logic             fast_periph_clk_en
);
   if (HRDY_CYCLES < 1 || HRDY_CYCLES >= (1 << SCM_HRDY_W))
   begin : g_bad_ready_count
      $error("HRDY_CYCLES out of range");
   end

   // Software state.
   logic [SCM_CKS_W-1:0] clock_divider_select;
   logic                 high_low_clock_select;
   logic                 idle_enable;
   logic                 fast_wake_enable;
   logic                 idle_sysclk_keep;
   logic                 tbase_sel_sys;
   scm_mode_t            mode;
   logic                 wake_bridge;
   logic                 fast_osc_ready_flag;
   logic [SCM_HRDY_W-1:0] ready_count;
   logic [SCM_DIV_W-1:0] div_count;
   logic [1:0]           tb_count;
   logic [1:0]           fast_sync;
   logic [1:0]           slow_sync;
   logic                 fast_prev;
   logic                 slow_prev;
   logic                 slow_is_xtal;
   logic                 pins_osc;
   logic                 straps_taken;

   // Two flip-flop synchronisers; edges are found after the second stage.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fast_sync <= 2'h0;
         slow_sync <= 2'h0;
         fast_prev <= 1'b0;
         slow_prev <= 1'b0;
      end
      else
      begin
         fast_sync <= {fast_sync[0], fast_osc_tick};
         slow_sync <= {slow_sync[0], slow_osc_tick};
         fast_prev <= fast_sync[1];
         slow_prev <= slow_sync[1];
      end
   end
   wire fast_edge = fast_sync[1] & ~fast_prev & fast_osc_enable;
   wire slow_edge = slow_sync[1] & ~slow_prev;

   // Straps are caught on the first clock after reset release.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         straps_taken <= 1'b0;
         slow_is_xtal <= 1'b0;
         pins_osc     <= 1'b0;
      end
      else if (!straps_taken)
      begin
         straps_taken <= 1'b1;
         slow_is_xtal <= cfg_slow_from_xtal;
         pins_osc     <= cfg_xtal_pins_osc | cfg_slow_from_xtal;
      end
   end

   // APB decode.
   wire       wr_en     = psel & penable & pwrite;
   wire       hit_mode  = paddr == SCM_MODE_ADDR;
   wire       hit_ctrl  = paddr == SCM_CTRL_ADDR;
   wire       hit_tbase = paddr == SCM_TBASE_ADDR;
   wire       hit_cmd   = paddr == SCM_CMD_ADDR;
   wire       hit_stat  = paddr == SCM_STAT_ADDR;
   wire       mapped    = hit_mode | hit_ctrl | hit_tbase | hit_cmd | hit_stat;
   wire       sw_halt   = wr_en & hit_cmd & pwdata[SCM_HALT_BIT];
   wire       sw_wake   = wr_en & hit_cmd & pwdata[SCM_WAKE_BIT];
   wire       do_halt   = halt_req | sw_halt;
   wire       do_wake   = wake_req | sw_wake;
   wire       running   = (mode == SCM_NORMAL) | (mode == SCM_SLOW);

   logic [31:0] rd_word;
   always_comb
   begin
      rd_word = 32'h0;
      if (hit_mode)
      begin
         rd_word[SCM_CKS_LSB +: SCM_CKS_W] = clock_divider_select;
         rd_word[SCM_FST_BIT]   = fast_wake_enable;
         rd_word[SCM_HRDY_BIT]  = fast_osc_ready_flag;
         rd_word[SCM_IDLE_ENABLE_BIT] = idle_enable;
         rd_word[SCM_HL_BIT]    = high_low_clock_select;
      end
      else if (hit_ctrl)
      begin
         rd_word[SCM_KEEP_BIT] = idle_sysclk_keep;
      end
      else if (hit_tbase)
      begin
         rd_word[SCM_SLOW_XTAL_POWER_SETTING_BIT] = slow_xtal_power_setting;
         rd_word[SCM_TBSEL_BIT] = tbase_sel_sys;
      end
      else if (hit_stat)
      begin
         rd_word[2:0] = mode;
      end
   end

   // Register file; pready answers in the first access cycle.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         clock_divider_select    <= SCM_CKS_RST;
         high_low_clock_select   <= SCM_HL_RST;
         idle_enable             <= SCM_IDLE_ENABLE_RST;
         fast_wake_enable        <= SCM_FST_RST;
         idle_sysclk_keep        <= 1'b0;
         tbase_sel_sys           <= 1'b0;
         slow_xtal_power_setting <= 1'b0;
         prdata                  <= 32'h0;
         pready                  <= 1'b0;
         pslverr                 <= 1'b0;
      end
      else
      begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped;
         if (psel & ~penable & ~pwrite)
         begin
            prdata <= rd_word;
         end
         if (wr_en & pready & hit_mode)
         begin
            clock_divider_select  <= pwdata[SCM_CKS_LSB +: SCM_CKS_W];
            high_low_clock_select <= pwdata[SCM_HL_BIT];
            idle_enable           <= pwdata[SCM_IDLE_ENABLE_BIT];
            fast_wake_enable      <= pwdata[SCM_FST_BIT];
         end
         if (wr_en & pready & hit_ctrl)
         begin
            idle_sysclk_keep <= pwdata[SCM_KEEP_BIT];
         end
         if (wr_en & pready & hit_tbase)
         begin
            // The crystal keeps running either way; only start-up current differs.
            slow_xtal_power_setting <= pwdata[SCM_SLOW_XTAL_POWER_SETTING_BIT];
            tbase_sel_sys           <= pwdata[SCM_TBSEL_BIT];
         end
      end
   end

   // Source selection.
   wire want_fast  = high_low_clock_select |
                     (clock_divider_select > 3'h1);
   wire sel_slow   = ~want_fast | wake_bridge;

   // Fast divider: ratio 2^(8 - field) for fields 2..7, undivided when select is 1.
   logic [SCM_DIV_W-1:0] div_mask;
   always_comb
   begin
      case (clock_divider_select)
         3'h2:    div_mask = 6'h3f;
         3'h3:    div_mask = 6'h1f;
         3'h4:    div_mask = 6'h0f;
         3'h5:    div_mask = 6'h07;
         3'h6:    div_mask = 6'h03;
         default: div_mask = 6'h01;
      endcase
   end
   wire fast_div_en = high_low_clock_select ? fast_edge :
                      fast_edge & ((div_count & div_mask) == div_mask);
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         div_count <= 6'h0;
      end
      else if (fast_edge)
      begin
         div_count <= div_count + 6'h1;
      end
   end

   logic sys_tick;
   logic on_slow;
   scm_glitch_mux u_mux
   (
      .pclk    (pclk),
      .presetn (presetn),
      .en_a    (fast_div_en),
      .en_b    (slow_edge),
      .pick_b  (sel_slow),
      .en_out  (sys_tick),
      .on_b    (on_slow)
   );

   // Mode sequencing.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mode        <= SCM_NORMAL;
         wake_bridge <= 1'b0;
      end
      else
      begin
         if (running & do_halt)
         begin
            if (idle_enable)
            begin
               mode <= idle_sysclk_keep ? SCM_IDLE_RUN : SCM_IDLE_STOP;
            end
            else
            begin
               mode <= SCM_LIGHT_SLEEP;
            end
         end
         else if (!running & do_wake)
         begin
            mode        <= want_fast ? SCM_NORMAL : SCM_SLOW;
            wake_bridge <= want_fast & fast_wake_enable;
         end
         else if (running)
         begin
            mode <= sel_slow & on_slow & ~wake_bridge ? SCM_SLOW : SCM_NORMAL;
            if (fast_osc_ready_flag)
            begin
               wake_bridge <= 1'b0;
            end
         end
      end
   end

   // Fast oscillator runs unless the slow source is chosen or the CPU is halted; in idle-run it stays on for a fast source.
   wire fast_needed = running ? (want_fast | ~on_slow) : (mode == SCM_IDLE_RUN & want_fast);
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fast_osc_enable     <= 1'b1;
         ready_count         <= '0;
         fast_osc_ready_flag <= 1'b0;
      end
      else
      begin
         fast_osc_enable <= fast_needed;
         if (!fast_osc_enable)
         begin
            ready_count         <= '0;
            fast_osc_ready_flag <= 1'b0;
         end
         else if (fast_edge & ~fast_osc_ready_flag)
         begin
            if (ready_count == SCM_HRDY_W'(HRDY_CYCLES - 1))
            begin
               fast_osc_ready_flag <= 1'b1;
            end
            ready_count <= ready_count + SCM_HRDY_W'(1);
         end
      end
   end
   // Time base divide by four of the system clock.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tb_count <= 2'h0;
      end
      else if (sys_tick)
      begin
         tb_count <= tb_count + 2'h1;
      end
   end

   wire sub_on   = mode != SCM_DEEP_SLEEP;
   wire sys_on   = running | (mode == SCM_IDLE_RUN);
   wire sys_q    = sys_tick & sys_on;
   wire tb_q     = tbase_sel_sys ? (sys_q & (tb_count == 2'h3)) : (slow_edge & sub_on);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cpu_clk_en          <= 1'b0;
         sys_clk_en          <= 1'b0;
         sub_clk_en          <= 1'b0;
         tbase_clk_en        <= 1'b0;
         periph_sub_clk_en   <= 1'b0;
         fast_periph_clk_en  <= 1'b0;
         slow_rc_enable      <= 1'b1;
         slow_xtal_enable    <= 1'b0;
         slow_xtal_pins_gpio <= 1'b1;
      end
      else
      begin
         cpu_clk_en          <= sys_tick & running;
         sys_clk_en          <= sys_q;
         sub_clk_en          <= slow_edge & sub_on;
         tbase_clk_en        <= tb_q;
         periph_sub_clk_en   <= slow_edge & sub_on;
         // Gated by the next enable too, so no pulse escapes as the oscillator stops.
         fast_periph_clk_en  <= fast_edge & ~on_slow & fast_needed;
         slow_rc_enable      <= ~slow_is_xtal & sub_on;
         slow_xtal_enable    <= slow_is_xtal & sub_on;
         slow_xtal_pins_gpio <= ~pins_osc;
      end
   end
endmodule : scm_clock_control
`default_nettype wire

//--- hdl/scm_glitch_mux.sv
// Glitch-free two-input clock enable selector.
`timescale 1ns/10ps
`default_nettype none
module scm_glitch_mux
(
   // Clock and reset.
   input  wire logic pclk,
   input  wire logic presetn,
   // Candidate enables and choice.
   input  wire logic en_a,
   input  wire logic en_b,
   input  wire logic pick_b,
   // Selected enable and which source is in use.
   output logic      en_out,
   output logic      on_b
);
   logic use_a;
   logic use_b;
   // Change only on a boundary of the running source, so no phase is cut short.
   wire  a_bound  = en_a;
   wire  b_bound  = en_b;
   wire  next_a   = ~pick_b & ~use_b & (use_a | a_bound);
   wire  next_b   = pick_b & ~use_a & (use_b | b_bound);
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         use_a <= 1'b1;
         use_b <= 1'b0;
      end
      else
      begin
         if (use_a ? (a_bound | ~pick_b) : 1'b1)
         begin
            use_a <= use_a ? ~(pick_b & a_bound) & 1'b1 | (~pick_b) : next_a;
         end
         if (use_b ? (b_bound | pick_b) : 1'b1)
         begin
            use_b <= use_b ? ~(~pick_b & b_bound) | pick_b : next_b;
         end
      end
   end
   assign en_out = (use_a & en_a) | (use_b & en_b);
   assign on_b   = use_b;
endmodule : scm_glitch_mux
`default_nettype wire

//--- inc/scm_pkg.sv
// Package with constants and types for the system clock and mode control block.
package scm_pkg;
   // Register byte addresses.
   localparam logic [11:0] SCM_MODE_ADDR   = 12'h000;
   localparam logic [11:0] SCM_CTRL_ADDR   = 12'h004;
   localparam logic [11:0] SCM_TBASE_ADDR  = 12'h008;
   localparam logic [11:0] SCM_CMD_ADDR    = 12'h00c;
   localparam logic [11:0] SCM_STAT_ADDR   = 12'h010;
   // Mode register fields.
   localparam int SCM_HL_BIT     = 0;
   localparam int SCM_IDLE_ENABLE_BIT  = 1;
   localparam int SCM_HRDY_BIT   = 2;
   localparam int SCM_FST_BIT    = 4;
   localparam int SCM_CKS_LSB    = 5;
   localparam int SCM_CKS_W      = 3;
   localparam logic [SCM_CKS_W-1:0] SCM_CKS_RST = 3'h6;
   localparam logic               SCM_IDLE_ENABLE_RST = 1'h1;
   localparam logic               SCM_HL_RST    = 1'h0;
   localparam logic               SCM_FST_RST   = 1'h0;
   // Control register fields.
   localparam int SCM_KEEP_BIT   = 7;
   // Time base register fields.
   localparam int SCM_SLOW_XTAL_POWER_SETTING_BIT  = 0;
   localparam int SCM_TBSEL_BIT  = 1;
   // Command register fields.
   localparam int SCM_HALT_BIT   = 0;
   localparam int SCM_WAKE_BIT   = 1;
   // Ready count of fast oscillator cycles.
   localparam int SCM_HRDY_CYCLES = 1024;
   localparam int SCM_HRDY_W      = 11;
   // Fast divider width for ratios up to 64.
   localparam int SCM_DIV_W       = 6;
   typedef enum logic [2:0] {
      SCM_NORMAL, SCM_SLOW, SCM_IDLE_STOP, SCM_IDLE_RUN, SCM_DEEP_SLEEP, SCM_LIGHT_SLEEP
   } scm_mode_t;
endpackage : scm_pkg

//--- verification/scm_clock_control_asserts.sv
// Concurrent checks on the ports of the clock and mode control block.
`timescale 1ns/10ps
`default_nettype none
module scm_clock_control_asserts
(
   // Clock and reset.
   input wire logic        pclk,
   input wire logic        presetn,
   // APB.
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Oscillator controls and enables.
   input wire logic        fast_osc_enable,
   input wire logic        slow_xtal_enable,
   input wire logic        slow_xtal_pins_gpio,
   input wire logic        slow_xtal_power_setting,
   input wire logic        cpu_clk_en,
   input wire logic        sys_clk_en,
   input wire logic        fast_periph_clk_en
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_apb_answer: assert property (psel && !penable |=> pready && psel && penable)
      else $error("pready late after setup");
   a_ready_single: assert property (pready |=> !pready)
      else $error("pready held too long");
   a_unmapped_err: assert property (pready && paddr > 12'h010 |-> pslverr)
      else $error("unmapped access not refused");
   a_refused_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read returned data");
   a_power_reset: assert property ($rose(presetn) |-> !slow_xtal_power_setting)
      else $error("power setting not quick start after reset");
   a_fast_gone: assert property (fast_periph_clk_en |-> fast_osc_enable)
      else $error("fast peripheral clock without fast oscillator");
   a_pins_by_xtal: assert property (slow_xtal_enable |-> !slow_xtal_pins_gpio)
      else $error("crystal pins left as general I/O");
   a_cpu_needs_sys: assert property (cpu_clk_en |-> sys_clk_en)
      else $error("cpu clocked without system clock");
   a_sys_no_runt: assert property (sys_clk_en |=> !sys_clk_en)
      else $error("system clock enable runt");
endmodule : scm_clock_control_asserts
bind scm_clock_control scm_clock_control_asserts i_scm_clock_control_asserts
(
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .fast_osc_enable(fast_osc_enable), .slow_xtal_enable(slow_xtal_enable),
   .slow_xtal_pins_gpio(slow_xtal_pins_gpio), .cpu_clk_en(cpu_clk_en),
   .slow_xtal_power_setting(slow_xtal_power_setting), .sys_clk_en(sys_clk_en),
   .fast_periph_clk_en(fast_periph_clk_en)
);
`default_nettype wire

//--- verification/scm_clock_control_tb_top.sv
// Self-checking bench for the clock and mode control block.
`timescale 1ns/10ps
`default_nettype none
module scm_clock_control_tb_top;
   import scm_pkg::*;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata;
   logic        pready, pslverr, strap = 0, pins = 0, halt = 0, wake = 0, ft, st, ft_q = 0;
   logic        fen, rcen, xen, pwr, gpio, cpu, sys, sub, tb, psub, fper;
   logic [64:0] notes[$], nt;
   int          mismatches = 0, checks = 0, cnt[5], d[5];
   always #4 pclk = ~pclk;
   scm_clock_control #(.HRDY_CYCLES(8)) i_scm_clock_control
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cfg_slow_from_xtal(strap), .cfg_xtal_pins_osc(pins), .fast_osc_tick(ft),
      .slow_osc_tick(st), .halt_req(halt), .wake_req(wake), .fast_osc_enable(fen),
      .slow_rc_enable(rcen), .slow_xtal_enable(xen), .slow_xtal_power_setting(pwr),
      .slow_xtal_pins_gpio(gpio), .cpu_clk_en(cpu), .sys_clk_en(sys), .sub_clk_en(sub),
      .tbase_clk_en(tb), .periph_sub_clk_en(psub), .fast_periph_clk_en(fper)
   );
   scm_osc_model i_scm_osc_model
   (
      .fast_en(fen), .rc_en(rcen), .xtal_en(xen), .fast_tick(ft), .slow_tick(st)
   );
   task automatic check(input string nm, input logic [31:0] s, input logic [31:0] x);
      checks++;
      if (s !== x)
      begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", nm, x, s);
      end
   endtask : check
   task automatic test_done();
      $display("mismatches %0d checks %0d", mismatches, checks);
      if (mismatches == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : test_done
   // The master notes what the answer must hold; the monitor compares it.
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] v,
                      input logic [31:0] m, input logic e);
      notes.push_back({e, m, v & m});
      // One idle edge first, so a strobe is never lowered and raised in one step.
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   always @(posedge pclk)
      if (psel && penable && pready)
      begin
         nt = notes.pop_front();
         check("pslverr", {31'h0, pslverr}, {31'h0, nt[64]});
         check("prdata", prdata & nt[63:32], nt[31:0]);
      end
   always @(posedge pclk)
   begin
      ft_q <= ft;
      cnt[0] <= cnt[0] + sys;
      cnt[1] <= cnt[1] + tb;
      cnt[2] <= cnt[2] + (ft && !ft_q);
      cnt[3] <= cnt[3] + cpu;
      cnt[4] <= cnt[4] + sub;
   end
   task automatic win(input int n);
      int s[5];
      s = cnt;
      repeat (n) @(posedge pclk);
      foreach (d[i]) d[i] = cnt[i] - s[i];
   endtask : win
   initial
   begin
      #400_000;
      mismatches++;
      test_done();
   end
   initial
   begin
      int k, r;
      r = $urandom(32'h909dfdab);
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (100) @(posedge pclk);
      check("rc enable", rcen, 1);
      apb(SCM_MODE_ADDR, 0, 32'hc6, 32'hf7, 0);
      apb(SCM_CTRL_ADDR, 0, 0, 32'h80, 0);
      apb(SCM_TBASE_ADDR, 0, 0, 1, 0);
      apb(SCM_STAT_ADDR, 0, 0, 7, 0);
      apb(12'h014, 1, 32'hff, 0, 1);
      apb(12'h014, 0, 0, 32'hffffffff, 1);
      for (k = 0; k < 8; k++)
      begin
         r = (k > 1) ? 64 >> (k - 2) : 1;
         apb(SCM_MODE_ADDR, 1, (k << 5) | 2, 0, 0);
         repeat (100) @(posedge pclk);
         apb(SCM_STAT_ADDR, 0, k < 2, 7, 0);
         apb(SCM_MODE_ADDR, 0, (k << 5) | ((k > 1) << 2) | 2, 32'hf7, 0);
         win(2000);
         check("fast enable", fen, k > 1);
         if (k > 1)
            check("sys rate", (d[0] - d[2] / r) inside {[-2:2]}, 1);
      end
      apb(SCM_MODE_ADDR, 1, 32'h3, 0, 0);
      apb(SCM_TBASE_ADDR, 1, 32'h2, 0, 0);
      repeat (100) @(posedge pclk);
      win(2000);
      check("sys fast", (d[0] - d[2]) inside {[-2:2]}, 1);
      check("tbase rate", (d[1] - d[0] / 4) inside {[-2:2]}, 1);
      apb(SCM_TBASE_ADDR, 1, 32'h3, 0, 0);
      apb(SCM_TBASE_ADDR, 0, 32'h3, 32'h3, 0);
      win(500);
      check("power setting", pwr, 1);
      check("slow running", d[4] > 0, 1);
      for (k = 0; k < 3; k++)
      begin
         apb(SCM_MODE_ADDR, 1, {k == 0, 2'b00, k < 2, 1'b1}, 0, 0);
         apb(SCM_CTRL_ADDR, 1, (k == 1) << 7, 0, 0);
         halt <= 1'b1;
         @(posedge pclk);
         halt <= 1'b0;
         repeat (20) @(posedge pclk);
         apb(SCM_STAT_ADDR, 0, (k == 2) ? 5 : k + 2, 7, 0);
         win(500);
         check("cpu halted", d[3], 0);
         check("sys in halt", d[0] > 0, k == 1);
         check("sub in halt", d[4] > 0, 1);
         wake <= 1'b1;
         @(posedge pclk);
         wake <= 1'b0;
         repeat (200) @(posedge pclk);
         apb(SCM_STAT_ADDR, 0, 0, 7, 0);
         win(200);
         check("cpu running", d[3] > 0, 1);
      end
      r = $urandom;
      apb(SCM_MODE_ADDR, 1, {r[2:0], 5'h02}, 0, 0);
      apb(SCM_MODE_ADDR, 0, {r[2:0], 5'h02}, 32'he3, 0);
      for (k = 0; k < 2; k++)
      begin
         strap <= k[0];
         pins <= !k[0];
         presetn <= 1'b0;
         repeat (8) @(posedge pclk);
         presetn <= 1'b1;
         repeat (4) @(posedge pclk);
         check("xtal enable", xen, k);
         check("rc enable", rcen, !k);
         check("pins gpio", gpio, 0);
      end
      test_done();
   end
endmodule : scm_clock_control_tb_top
`default_nettype wire

//--- verification/scm_osc_model.sv
// Behavioural model of the fast crystal and the two slow oscillators.
`timescale 1ns/10ps
`default_nettype none
module scm_osc_model
(
   // Enables from the block.
   input  wire logic fast_en,
   input  wire logic rc_en,
   input  wire logic xtal_en,
   // Oscillator waveforms.
   output logic      fast_tick,
   output logic      slow_tick
);
   initial fast_tick = 1'b0;
   initial slow_tick = 1'b0;
   // A stopped oscillator stands low, so stale edges cannot be counted.
   always #17 fast_tick = fast_en ? ~fast_tick : 1'b0;
   // Power setting is ignored: the crystal keeps running in both.
   always #61 slow_tick = (rc_en || xtal_en) ? ~slow_tick : 1'b0;
endmodule : scm_osc_model
`default_nettype wire
